// ===== rtl/bsb_pkg.sv
package bsb_pkg;

    // Program counter width in words
    localparam int PC_W_DEF = 16;
    localparam logic [15:0] PC_RST = 16'h0000;

    // Status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Opcode masks and patterns
    localparam logic [15:0] OPM_CPI  = 16'hf000;
    localparam logic [15:0] OPP_CPI  = 16'h3000;
    localparam logic [15:0] OPM_RBIT = 16'hfe08;
    localparam logic [15:0] OPP_SRC  = 16'hfc00;
    localparam logic [15:0] OPP_SRS  = 16'hfe00;
    localparam logic [15:0] OPP_BST  = 16'hfa00;
    localparam logic [15:0] OPM_IO   = 16'hff00;
    localparam logic [15:0] OPP_CBI  = 16'h9800;
    localparam logic [15:0] OPP_SIC  = 16'h9900;
    localparam logic [15:0] OPP_SBI  = 16'h9a00;
    localparam logic [15:0] OPP_SIS  = 16'h9b00;
    localparam logic [15:0] OPM_BR   = 16'hf800;
    localparam logic [15:0] OPP_BR   = 16'hf000;
    localparam logic [15:0] OPM_ROL  = 16'hfc00;
    localparam logic [15:0] OPP_ROL  = 16'h1c00;
    localparam logic [15:0] OPM_ROR  = 16'hfe0f;
    localparam logic [15:0] OPP_ROR  = 16'h9407;
    localparam int          BR_OFF_W = 7;

    // Program counter steps and extra wait cycles
    localparam logic [1:0] PC_SKIP_ONE  = 2'h2;
    localparam logic [1:0] PC_SKIP_TWO  = 2'h3;
    localparam logic [1:0] WAIT_BR      = 2'h1;
    localparam logic [1:0] WAIT_SKIP1   = 2'h1;
    localparam logic [1:0] WAIT_SKIP2   = 2'h2;

    // Bus register map
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_FLAGS   = 8'h04;
    localparam logic [7:0]  REG_STATUS  = 8'h08;
    localparam int          CTRL_EN_BIT = 0;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_PC_LSB = 16;

    typedef struct packed {
        logic [15:0] opcode;
        logic        next_two_word;
    } bsb_instr_t;

    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [7:0] data;
    } bsb_rf_wr_t;

    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [7:0] data;
        logic [7:0] mask;
    } bsb_io_wr_t;

    typedef enum logic [2:0] {
        ALU_CMP = 3'b001,
        ALU_ROL = 3'b010,
        ALU_ROR = 3'b100
    } bsb_alu_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_IOWR = 3'b100
    } bsb_state_t;

endpackage

// ===== rtl/bsb_shift_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module bsb_shift_cmp
    import bsb_pkg::*;
(
    input  wire bsb_pkg::bsb_alu_op_t alu_op,
    input  wire logic [7:0]           a,
    input  wire logic [7:0]           k,
    input  wire logic                 cin,
    output logic [7:0]                res,
    output logic                      c,
    output logic                      z,
    output logic                      n,
    output logic                      v,
    output logic                      h
);
    // Subtract-without-store and rotates through carry
    always_comb begin
        res = 8'h00;
        c   = 1'b0;
        h   = 1'b0;
        v   = 1'b0;
        unique case (alu_op)
            ALU_CMP: begin
                res = a - k;
                c   = (~a[7] & k[7]) | (k[7] & res[7]) | (res[7] & ~a[7]);
                h   = (~a[3] & k[3]) | (k[3] & res[3]) | (res[3] & ~a[3]);
                v   = (a[7] & ~k[7] & ~res[7]) | (~a[7] & k[7] & res[7]);
            end
            ALU_ROL: begin
                res = {a[6:0], cin};
                c   = a[7];
                v   = res[7] ^ a[7];
            end
            ALU_ROR: begin
                res = {cin, a[7:1]};
                c   = a[0];
                v   = res[7] ^ a[0];
            end
            default: begin
                res = 8'h00;
            end
        endcase
        n = res[7];
        z = (res == 8'h00);
    end
endmodule
`default_nettype wire

// ===== rtl/bsb_ahb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module bsb_ahb_regs
    import bsb_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    input  wire logic            core_clk,
    input  wire logic            reset,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    output logic                 exec_en,
    output logic                 flag_wr,
    output logic [7:0]           flag_wdata,
    input  wire logic [7:0]      flags,
    input  wire logic [PC_W-1:0] pc,
    input  wire logic            busy
);
    logic       dph_wr_q;
    logic [7:0] dph_addr_q;
    logic       ctrl_en_q;
    logic       aph;

    // Zero wait states, so the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign aph       = hsel & hready & htrans[1];
    assign exec_en   = ctrl_en_q;

    // Address phase capture; only whole words are used
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
        end else begin
            dph_wr_q   <= aph & hwrite & (hsize == 3'h2);
            dph_addr_q <= haddr[7:0];
        end
    end

    // Read data sampled in the address phase; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (aph & ~hwrite) begin
            unique case (haddr[7:0])
                REG_CTRL:   hrdata <= 32'(ctrl_en_q);
                REG_FLAGS:  hrdata <= 32'(flags);
                REG_STATUS: hrdata <= (32'(pc) << STAT_PC_LSB) | (32'(busy) << STAT_BUSY);
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control write in the data phase
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_en_q <= CTRL_EN_RST;
        end else if (dph_wr_q && dph_addr_q == REG_CTRL) begin
            ctrl_en_q <= hwdata[CTRL_EN_BIT];
        end
    end

    // Flag preload strobe, taken by the core on the same edge
    assign flag_wr    = dph_wr_q && (dph_addr_q == REG_FLAGS);
    assign flag_wdata = hwdata[7:0];
endmodule
`default_nettype wire

// ===== rtl/bsb_core.sv
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Compare with constant subtracts, stores nothing, sets Z N V C H, one cycle.
// - Skip on register bit clear steps over next instruction, PC plus 2 or 3.
// - Skip on register bit set steps over next instruction, flags untouched.
// - I/O bit skips test one I/O bit, skip on zero or one.
// - Flag-index branch jumps to PC+k+1 on chosen flag state; 1 or 2 cycles.
// - Carry branches jump on carry one or carry zero, target PC+k+1.
// - Signed branches test N xor V; ge on zero, less on one.
// - Half-carry branches jump on H one or H zero.
// - Transfer-flag branches jump on T set or clear, 1 or 2 cycles.
// - Overflow branches jump on V one or zero, flags unchanged.
// - Interrupt-state branches jump on I one or zero, I unchanged.
// - I/O bit set forces one bit high in two cycles, no flags.
// - I/O bit clear forces exactly one bit low in two cycles.
// - Rotate up via carry: C into bit 0, bit 7 into C; Z C N V.
// - Rotate down via carry: C into bit 7, bit 0 into C; Z C N V.
// - Register bit to transfer flag copies one bit into T only.
module bsb_core
    import bsb_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                instr_valid,
    input  wire bsb_pkg::bsb_instr_t instr,
    output logic                     instr_ready,
    output logic                     op_done,
    output logic                     op_unhandled,
    output logic [4:0]               rf_raddr,
    input  wire logic [7:0]          rf_rdata,
    output bsb_pkg::bsb_rf_wr_t      rf_wr,
    output logic [4:0]               io_raddr,
    input  wire logic [7:0]          io_rdata,
    output bsb_pkg::bsb_io_wr_t      io_wr,
    output logic [PC_W-1:0]          pc,
    output logic [7:0]               flags,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata
);
    import bsb_pkg::*;

    logic [PC_W-1:0] pc_q;
    logic [7:0]      flags_q;
    bsb_state_t      state_q;
    logic [1:0]      wait_cnt_q;
    bsb_io_wr_t      io_wr_q;
    logic            exec_en;
    logic            flag_wr;
    logic [7:0]      flag_wdata;
    logic            go;
    logic [15:0]     op;
    logic            is_cpi, is_src, is_srs, is_sic, is_sis, is_sbi, is_cbi;
    logic            is_br, is_rol, is_ror, is_bst, is_iobit, handled;
    logic            reg_bit, io_bit, fval, br_take, skip_take, multi;
    logic [7:0]      bit_mask;
    logic [PC_W-1:0] br_off, br_target;
    logic [1:0]      skip_step, skip_wait;
    bsb_alu_op_t     alu_op;
    logic [7:0]      alu_res;
    logic            alu_c, alu_z, alu_n, alu_v, alu_h;

    // Register slave on the bus
    bsb_ahb_regs #(
        .PC_W (PC_W)
    ) u_regs (
        .core_clk   (core_clk),
        .reset      (reset),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hready),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .hrdata     (hrdata),
        .exec_en    (exec_en),
        .flag_wr    (flag_wr),
        .flag_wdata (flag_wdata),
        .flags      (flags_q),
        .pc         (pc_q),
        .busy       (state_q != ST_IDLE)
    );

    // Issue handshake; software can halt issue through the control register
    assign instr_ready = (state_q == ST_IDLE) & exec_en;
    assign go          = instr_valid & instr_ready;
    assign op          = instr.opcode;

    // Opcode decode
    assign is_cpi   = (op & OPM_CPI) == OPP_CPI;
    assign is_src   = (op & OPM_RBIT) == OPP_SRC;
    assign is_srs   = (op & OPM_RBIT) == OPP_SRS;
    assign is_bst   = (op & OPM_RBIT) == OPP_BST;
    assign is_cbi   = (op & OPM_IO) == OPP_CBI;
    assign is_sic   = (op & OPM_IO) == OPP_SIC;
    assign is_sbi   = (op & OPM_IO) == OPP_SBI;
    assign is_sis   = (op & OPM_IO) == OPP_SIS;
    assign is_br    = (op & OPM_BR) == OPP_BR;
    // Rotate up is the add-with-carry of a register onto itself
    assign is_rol   = ((op & OPM_ROL) == OPP_ROL) && (op[8:4] == {op[9], op[3:0]});
    assign is_ror   = (op & OPM_ROR) == OPP_ROR;
    assign is_iobit = is_sbi | is_cbi;
    assign handled  = is_cpi | is_src | is_srs | is_bst | is_cbi | is_sic | is_sbi | is_sis
                      | is_br | is_rol | is_ror;
    assign op_unhandled = go & ~handled;

    // Operand fetch; constant compare reaches only the upper sixteen registers
    assign rf_raddr = is_cpi ? {1'b1, op[7:4]} : op[8:4];
    assign io_raddr = op[7:3];
    assign reg_bit  = rf_rdata[op[2:0]];
    assign io_bit   = io_rdata[op[2:0]];
    assign bit_mask = 8'h01 << op[2:0];

    // Skip decision and step size from the length of the skipped word
    assign skip_take = (is_src & ~reg_bit) | (is_srs & reg_bit)
                       | (is_sic & ~io_bit) | (is_sis & io_bit);
    assign skip_step = instr.next_two_word ? PC_SKIP_TWO : PC_SKIP_ONE;
    assign skip_wait = instr.next_two_word ? WAIT_SKIP2 : WAIT_SKIP1;

    // Flag branch: index selects the flag, sign slot is N xor V live
    always_comb begin
        fval = flags_q[op[2:0]];
        if (op[2:0] == FLAG_S) begin
            fval = flags_q[FLAG_N] ^ flags_q[FLAG_V];
        end
    end
    // Bit 10 chooses branch on clear; carry, H, T, V, I follow by index
    assign br_take   = is_br & (fval ^ op[10]);
    assign br_off    = {{(PC_W - BR_OFF_W){op[9]}}, op[9:3]};
    assign br_target = pc_q + br_off + PC_W'(1);
    assign multi     = br_take | skip_take;

    // Compare and rotates share one small datapath
    always_comb begin
        alu_op = ALU_CMP;
        if (is_rol) begin
            alu_op = ALU_ROL;
        end else if (is_ror) begin
            alu_op = ALU_ROR;
        end
    end

    bsb_shift_cmp u_alu (
        .alu_op (alu_op),
        .a      (rf_rdata),
        .k      ({op[11:8], op[3:0]}),
        .cin    (flags_q[FLAG_C]),
        .res    (alu_res),
        .c      (alu_c),
        .z      (alu_z),
        .n      (alu_n),
        .v      (alu_v),
        .h      (alu_h)
    );

    // Write-back strobe; compare never writes
    assign rf_wr.we   = go & (is_rol | is_ror);
    assign rf_wr.addr = op[8:4];
    assign rf_wr.data = alu_res;

    // Program counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_q <= PC_W'(PC_RST);
        end else if (go) begin
            if (br_take) begin
                pc_q <= br_target;
            end else if (skip_take) begin
                pc_q <= pc_q + PC_W'(skip_step);
            end else begin
                pc_q <= pc_q + PC_W'(1);
            end
        end
    end

    // Flags: a bus preload first, then the instruction's own bits win
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_q <= FLAGS_RST;
        end else begin
            if (flag_wr) begin
                flags_q <= flag_wdata;
            end
            if (go && is_cpi) begin
                flags_q[FLAG_Z] <= alu_z;
                flags_q[FLAG_N] <= alu_n;
                flags_q[FLAG_V] <= alu_v;
                flags_q[FLAG_C] <= alu_c;
                flags_q[FLAG_H] <= alu_h;
            end
            if (go && (is_rol || is_ror)) begin
                flags_q[FLAG_Z] <= alu_z;
                flags_q[FLAG_N] <= alu_n;
                flags_q[FLAG_V] <= alu_v;
                flags_q[FLAG_C] <= alu_c;
            end
            if (go && is_bst) begin
                flags_q[FLAG_T] <= reg_bit;
            end
        end
    end

    // Sequencer for taken skips, taken branches and I/O bit writes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            wait_cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (go && is_iobit) begin
                        state_q <= ST_IOWR;
                    end else if (go && multi) begin
                        state_q    <= ST_WAIT;
                        wait_cnt_q <= br_take ? WAIT_BR : skip_wait;
                    end
                end
                ST_WAIT: begin
                    wait_cnt_q <= wait_cnt_q - 2'h1;
                    if (wait_cnt_q == 2'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IOWR: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Read in the first cycle, write one bit in the second; neighbours
    // keep the value read, and the mask lets flag-clearing registers act
    always_ff @(posedge core_clk) begin
        if (reset) begin
            io_wr_q <= '0;
        end else if (go && is_iobit) begin
            io_wr_q.we   <= 1'b1;
            io_wr_q.addr <= op[7:3];
            io_wr_q.mask <= bit_mask;
            io_wr_q.data <= is_sbi ? (io_rdata | bit_mask) : (io_rdata & ~bit_mask);
        end else begin
            io_wr_q.we <= 1'b0;
        end
    end

    assign io_wr   = io_wr_q;
    assign pc      = pc_q;
    assign flags   = flags_q;
    assign op_done = (go & ~is_iobit & ~multi) | ((state_q == ST_WAIT) & (wait_cnt_q == 2'h1))
                     | (state_q == ST_IOWR);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_cpi_nowrite;
        go && is_cpi |-> !rf_wr.we ##1 (flags_q[FLAG_Z] == $past(rf_rdata == {op[11:8], op[3:0]}));
    endproperty
    a_cpi_nowrite: assert property (p_cpi_nowrite) else $error("compare wrote back or bad Z");

    property p_skip_clr;
        go && is_src && !reg_bit && !instr.next_two_word |=> pc_q == $past(pc_q) + PC_W'(2);
    endproperty
    a_skip_clr: assert property (p_skip_clr) else $error("register-bit skip step wrong");

    property p_skip_set_flags;
        go && is_srs && !flag_wr |=> flags_q == $past(flags_q);
    endproperty
    a_skip_set_flags: assert property (p_skip_set_flags) else $error("skip changed flags");

    property p_io_skip;
        go && (is_sic || is_sis) && (io_bit == is_sis) && instr.next_two_word
            |=> pc_q == $past(pc_q) + PC_W'(3) ##0 state_q == ST_WAIT [*2] ##1 state_q == ST_IDLE;
    endproperty
    a_io_skip: assert property (p_io_skip) else $error("I/O skip step or timing wrong");

    property p_br_taken;
        go && br_take |=> pc_q == $past(br_target) ##0 !instr_ready ##1 state_q == ST_IDLE;
    endproperty
    a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");

    property p_br_not;
        go && is_br && !br_take |=> pc_q == $past(pc_q) + PC_W'(1) ##0 state_q == ST_IDLE;
    endproperty
    a_br_not: assert property (p_br_not) else $error("untaken branch wrong");

    property p_signed;
        go && is_br && op[2:0] == FLAG_S |-> br_take == (flags_q[FLAG_N] ^ flags_q[FLAG_V] ^ op[10]);
    endproperty
    a_signed: assert property (p_signed) else $error("signed branch test wrong");

    property p_io_set;
        go && is_sbi |=> io_wr.we && io_wr.data == ($past(io_rdata) | $past(bit_mask)) ##1 !io_wr.we;
    endproperty
    a_io_set: assert property (p_io_set) else $error("I/O bit set wrong");

    property p_io_clr;
        go && is_cbi |=> io_wr.we && io_wr.data == ($past(io_rdata) & ~$past(bit_mask));
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("I/O bit clear wrong");

    property p_rot;
        go && (is_rol || is_ror) |-> rf_wr.we ##1 flags_q[FLAG_C] == $past(is_rol ? rf_rdata[7] : rf_rdata[0]);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate carry wrong");

    property p_bst;
        go && is_bst |=> flags_q[FLAG_T] == $past(reg_bit);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store to T wrong");

    c_br_taken: cover property (go && br_take);
    c_skip_two: cover property (go && skip_take && instr.next_two_word);
    c_io_set:   cover property (go && is_sbi);
    c_rol:      cover property (go && is_rol);
endmodule
`default_nettype wire

// ===== verification/bsb_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bsb_core_tb;
    import bsb_pkg::*;
    logic                core_clk, reset, instr_valid, instr_ready, op_done, op_unhandled;
    logic                hsel, hwrite, hreadyout, hresp;
    bsb_pkg::bsb_instr_t instr;
    bsb_pkg::bsb_rf_wr_t rf_wr;
    bsb_pkg::bsb_io_wr_t io_wr;
    logic [4:0]          rf_raddr, io_raddr;
    logic [7:0]          rf_rdata, io_rdata, flags, ef;
    logic [15:0]         pc, epc, rnd;
    logic [31:0]         haddr, hwdata, hrdata, rd;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [9:0]          obs;
    logic [33:0]         expq[$];
    int                  n_errors = 0, check_count = 0, cyc = 0, t0 = 0;

    bsb_core #(.PC_W(16)) dut (.core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .op_done(op_done), .op_unhandled(op_unhandled), .rf_raddr(rf_raddr),
        .rf_rdata(rf_rdata), .rf_wr(rf_wr), .io_raddr(io_raddr), .io_rdata(io_rdata), .io_wr(io_wr), .pc(pc),
        .flags(flags), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    // 200 MHz core clock and a free cycle count for latency checks
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait on issue ready or bus ready, sampled mid-cycle to dodge edge races
    task automatic await(input bit bus);
        for (int i = 0; i <= 40; i++) begin
            @(negedge core_clk);
            if ((bus ? hreadyout : instr_ready) === 1'b1) return;
        end
        n_errors++;
        $display("Error at %0t: wait got %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask

    // Galois-free shift register stepping the random stream
    function automatic logic [15:0] nx();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction

    // One single-word AHB-Lite transfer; read data taken at the data phase edge
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        await(1'b1);
        @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        await(1'b1);
        r = hrdata;
        @(posedge core_clk);
    endtask

    // Reference model of the slice, then the issue handshake
    task automatic issue(input logic [15:0] op, input logic two, input logic [7:0] a);
        logic [7:0]  k, d, r, m;
        logic [15:0] st;
        logic [1:0]  l;
        logic        b;
        logic [4:0]  ra;
        k = {op[11:8], op[3:0]};
        m = 8'h01 << op[2:0];
        b = a[op[2:0]];
        d = 8'h00;
        l = 2'h0;
        st = 16'h0001;
        // Compare reads only the upper half of the register file
        ra = ((op & OPM_CPI) == OPP_CPI) ? {1'b1, op[7:4]} : op[8:4];
        if ((op & OPM_CPI) == OPP_CPI) begin
            r = a - k;
            ef[FLAG_C] = a < k;
            ef[FLAG_H] = (~a[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~a[3]);
            ef[FLAG_V] = (a[7] & ~k[7] & ~r[7]) | (~a[7] & k[7] & r[7]);
            ef[FLAG_Z] = r == 8'h00;
            ef[FLAG_N] = r[7];
        end else if ((op & OPM_ROL) == OPP_ROL || (op & OPM_ROR) == OPP_ROR) begin
            d = op[15] ? {ef[FLAG_C], a[7:1]} : {a[6:0], ef[FLAG_C]};
            ef[FLAG_C] = op[15] ? a[0] : a[7];
            ef[FLAG_Z] = d == 8'h00;
            ef[FLAG_N] = d[7];
            ef[FLAG_V] = d[7] ^ ef[FLAG_C];
        end else if ((op & OPM_RBIT) == OPP_BST) begin
            ef[FLAG_T] = b;
        end else if ((op & OPM_BR) == OPP_BR) begin
            // Index 4 is the live sign test, never the stored bit
            if (((op[2:0] == FLAG_S) ? ef[FLAG_N] ^ ef[FLAG_V] : ef[op[2:0]]) != op[10]) begin
                st = {{9{op[9]}}, op[9:3]} + 16'h0001;
                l = 2'h1;
            end
        end else if ((op & OPM_IO) == OPP_SBI || (op & OPM_IO) == OPP_CBI) begin
            d = op[9] ? (a | m) : (a & ~m);
            l = 2'h1;
        end else if (op[15] && b == op[9]) begin
            st = two ? 16'h0003 : 16'h0002;
            l = two ? 2'h2 : 2'h1;
        end
        epc = epc + st;
        @(posedge core_clk);
        expq.push_back({epc, ef, l, d});
        instr_valid <= 1'b1;
        instr <= {op, two};
        rf_rdata <= a;
        io_rdata <= a;
        await(1'b0);
        chk({23'h0, op_unhandled, rf_raddr, io_raddr}, {23'h0, op == 16'h0000, ra, op[7:3]});
        @(posedge core_clk);
        instr_valid <= 1'b0;
    endtask

    // Watcher: latency and write data in the done cycle, pc and flags just after it
    always @(negedge core_clk) begin
        if (instr_valid && instr_ready) t0 = cyc;
        if (op_done === 1'b1) begin
            obs = {2'(cyc - t0), rf_wr.we ? rf_wr.data : (io_wr.we ? io_wr.data : 8'h00)};
            @(posedge core_clk);
            #1;
            if (expq.size() == 0) chk({pc, flags, obs}, ~{pc, flags, obs});
            else chk({pc, flags, obs}, expq.pop_front());
        end
    end

    initial begin
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        rf_rdata = 8'h00;
        io_rdata = 8'h00;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        epc = PC_RST;
        ef = FLAGS_RST;
        rnd = 16'h74b8;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        ahb(1'b0, 32'h0000_000c, 32'h0, rd);
        chk({2'h0, rd}, 34'h0);
        // Issue halted through the control register, then enabled again
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h0, rd);
        ahb(1'b0, {24'h0, REG_CTRL}, 32'h0, rd);
        @(negedge core_clk);
        chk({1'b0, instr_ready, rd}, 34'h0);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h1, rd);
        // First compare has equal operands for the zero and no-borrow corner
        for (int i = 0; i < 6; i++) begin
            void'(nx());
            issue(OPP_CPI | (rnd & 16'h0fff), 1'b0, (i == 0) ? {rnd[11:8], rnd[3:0]} : rnd[15:8]);
        end
        for (int i = 0; i < 4; i++) begin
            void'(nx());
            issue(OPP_ROL | {6'h0, rnd[4], rnd[4], rnd[3:0], rnd[3:0]}, 1'b0, rnd[15:8]);
            issue(OPP_ROR | {7'h0, rnd[4:0], 4'h0}, 1'b0, rnd[14:7]);
            issue(OPP_BST | {7'h0, rnd[4:0], 1'b0, rnd[7:5]}, 1'b0, rnd[15:8]);
            issue((rnd[0] ? OPP_SBI : OPP_CBI) | {8'h0, rnd[7:0]}, 1'b0, rnd[15:8]);
        end
        $display("compare, rotate, bit store and io write tests done");
        for (int i = 0; i < 16; i++) begin
            void'(nx());
            issue(((i % 4 == 0) ? OPP_SRC : (i % 4 == 1) ? OPP_SRS : (i % 4 == 2) ? OPP_SIC : OPP_SIS)
                | {8'h0, rnd[7:4], 1'b0, rnd[2:0]}, rnd[8], rnd[15:8]);
        end
        // An opcode outside the slice still steps the counter by one
        issue(16'h0000, 1'b0, 8'h00);
        $display("skip tests done");
        // Every flag index, both polarities, chosen bit forced both ways, signed offsets
        for (int s = 0; s < 8; s++) begin
            for (int j = 0; j < 4; j++) begin
                void'(nx());
                ef = rnd[7:0];
                ef[s] = j[1];
                ahb(1'b1, {24'h0, REG_FLAGS}, {24'h0, ef}, rd);
                ahb(1'b0, {24'h0, REG_FLAGS}, 32'h0, rd);
                chk({2'h0, rd}, {26'h0, ef});
                issue(OPP_BR | {5'h0, j[0], rnd[15:9], 3'(s)}, 1'b0, 8'h00);
            end
        end
        for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge core_clk);
        chk({32'h0, expq.size() == 0}, 34'h1);
        ahb(1'b0, {24'h0, REG_STATUS}, 32'h0, rd);
        chk({2'h0, rd}, {2'h0, epc, 16'h0000});
        $display("branch and status tests done");
        results();
    end
endmodule
`default_nettype wire
